/* File: src/adc_seq_pkg.sv */
// Constants and types shared by the converter sequencer files.
// Assumes a single 25 MHz system clock and a synchronous active-low reset.
package adc_seq_pkg;

	// ****************************************************************
	// Widths and reset values
	// ****************************************************************
	localparam int RESULT_W = 10;
	localparam logic [2:0] ACQ_SEL_RESET = 3'h0;
	localparam logic [2:0] CLK_SEL_RESET = 3'h0;
	localparam logic [4:0] CONV_PERIODS = 5'h0b;
	localparam logic [4:0] POST_WAIT_PERIODS = 5'h02;
	// One instruction cycle is four oscillator periods.
	localparam logic [7:0] INSTR_CYCLE_CLKS = 8'h04;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START_DELAY,
		ST_ACQUIRE,
		ST_CONVERT,
		ST_POST_WAIT
	} seq_state_t;

endpackage : adc_seq_pkg

/* File: src/adc_bit_clock.sv */
// Bit-period enable generator for the converter sequencer.
// Assumes the RC clock arrives asynchronously on a pin.
`timescale 1ns/1ns
`default_nettype none

module adc_bit_clock (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic run_in,
	input wire logic [2:0] conv_clk_sel_in,
	input wire logic rc_clk_in,
	output logic tick_out
);

	// ****************************************************************
	// Divisor decode
	// ****************************************************************
	logic [7:0] div_max;
	logic use_rc;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic rc_s1_q;
	logic rc_s2_q;
	logic rc_s3_q;

	// Selector decode; x11 picks the RC source.
	always_comb begin
		use_rc = (conv_clk_sel_in[1:0] == 2'h3);
		unique case (conv_clk_sel_in)
			3'h0: div_max = 8'h01;
			3'h4: div_max = 8'h03;
			3'h1: div_max = 8'h07;
			3'h5: div_max = 8'h0f;
			3'h2: div_max = 8'h1f;
			3'h6: div_max = 8'h3f;
			default: div_max = 8'h01;
		endcase
	end

	// Counter restarts whenever the sequencer stops, so every period is whole.
	always_comb begin
		cnt_d = cnt_q;
		if (!run_in || use_rc) begin
			cnt_d = 8'h00;
		end else if (cnt_q == div_max) begin
			cnt_d = 8'h00;
		end else begin
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			cnt_q <= 8'h00;
			rc_s1_q <= 1'b0;
			rc_s2_q <= 1'b0;
			rc_s3_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			rc_s1_q <= rc_clk_in;
			rc_s2_q <= rc_s1_q;
			rc_s3_q <= rc_s2_q;
		end
	end

	// One pulse per bit period from either source.
	assign tick_out = run_in && (use_rc ? (rc_s2_q && !rc_s3_q)
		: (cnt_q == div_max));

	a_div_period: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(run_in && !use_rc && conv_clk_sel_in == 3'h0 && tick_out)
		|=> !tick_out) else $error("divide-by-two tick repeated");

endmodule : adc_bit_clock

`default_nettype wire

/* File: src/adc_sar_core.sv */
// Successive-approximation register for a ten-bit result.
// Assumes a comparator level that is already synchronous to clk_in.
`timescale 1ns/1ns
`default_nettype none

module adc_sar_core #(
	parameter int W = adc_seq_pkg::RESULT_W
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic start_in,
	input wire logic step_in,
	input wire logic comp_above_in,
	output logic [W-1:0] trial_out,
	output logic [W-1:0] value_out
);

	// ****************************************************************
	// Bit trials
	// ****************************************************************
	logic [W-1:0] val_q;
	logic [W-1:0] val_d;
	logic [W-1:0] mask_q;
	logic [W-1:0] mask_d;

	// Each step keeps or drops the trial bit, then moves to the next.
	always_comb begin
		val_d = val_q;
		mask_d = mask_q;
		if (start_in) begin
			val_d = '0;
			mask_d = {1'b1, {(W-1){1'b0}}};
		end else if (step_in && mask_q != '0) begin
			if (comp_above_in) begin
				val_d = val_q | mask_q;
			end
			mask_d = mask_q >> 1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			val_q <= '0;
			mask_q <= '0;
		end else begin
			val_q <= val_d;
			mask_q <= mask_d;
		end
	end

	assign trial_out = val_q | mask_q;
	assign value_out = val_q;

endmodule : adc_sar_core

`default_nettype wire

/* File: src/adc_acquire_convert_sequencer.sv */
// Acquire and convert sequencer for the ten-bit converter.
// Assumes control bits come from same-clock register logic; pins and the
// comparator arrive asynchronously and are synchronised here.
`timescale 1ns/1ns
`default_nettype none

module adc_acquire_convert_sequencer #(
	parameter int NPINS = 13
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic conv_power_on_in,
	input wire logic go_set_in,
	input wire logic go_clr_in,
	input wire logic trigger_in,
	input wire logic [2:0] acq_time_sel_in,
	input wire logic [2:0] conv_clk_sel_in,
	input wire logic result_justify_sel_in,
	input wire logic result_wr_in,
	input wire logic [7:0] result_high_byte_wr_in,
	input wire logic [7:0] result_low_byte_wr_in,
	input wire logic done_flag_clr_in,
	input wire logic rc_clk_in,
	input wire logic comp_above_in,
	input wire logic [NPINS-1:0] pin_level_in,
	input wire logic [NPINS-1:0] pin_analog_in,
	output logic go_out,
	output logic conv_done_irq_flag_out,
	output logic sample_connect_out,
	output logic [adc_seq_pkg::RESULT_W-1:0] dac_trial_out,
	output logic [7:0] result_high_byte_out,
	output logic [7:0] result_low_byte_out,
	output logic [NPINS-1:0] port_read_out
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int W = adc_seq_pkg::RESULT_W;
	adc_seq_pkg::seq_state_t st_q;
	adc_seq_pkg::seq_state_t st_d;
	logic go_q;
	logic go_d;
	logic flag_q;
	logic flag_d;
	logic [4:0] per_q;
	logic [4:0] per_d;
	logic [7:0] dly_q;
	logic [7:0] dly_d;
	logic [7:0] rh_q;
	logic [7:0] rh_d;
	logic [7:0] rl_q;
	logic [7:0] rl_d;
	logic [4:0] acq_periods;
	logic tick;
	logic run;
	logic sar_start;
	logic done_evt;
	logic [W-1:0] sar_val;
	logic cmp_s1_q;
	logic cmp_s2_q;
	logic [NPINS-1:0] pin_s1_q;
	logic [NPINS-1:0] pin_s2_q;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// The comparator and the pins are asynchronous to clk_in.
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			cmp_s1_q <= comp_above_in;
			cmp_s2_q <= cmp_s1_q;
			pin_s1_q <= pin_level_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Analog pins read back as zero, one generate over the pins.
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_pin
			assign port_read_out[gi] = pin_s2_q[gi] & ~pin_analog_in[gi];
		end
	endgenerate

	// ****************************************************************
	// Acquisition selector decode
	// ****************************************************************
	// Selector steps to 0, 2, 4, 6, 8, 12, 16 and 20 bit periods.
	always_comb begin
		unique case (acq_time_sel_in)
			3'h0: acq_periods = 5'h00;
			3'h1: acq_periods = 5'h02;
			3'h2: acq_periods = 5'h04;
			3'h3: acq_periods = 5'h06;
			3'h4: acq_periods = 5'h08;
			3'h5: acq_periods = 5'h0c;
			3'h6: acq_periods = 5'h10;
			3'h7: acq_periods = 5'h14;
		endcase
	end

	// ****************************************************************
	// Bit clock and SAR
	// ****************************************************************
	assign run = (st_q == adc_seq_pkg::ST_ACQUIRE) || (st_q == adc_seq_pkg::ST_CONVERT)
		|| (st_q == adc_seq_pkg::ST_POST_WAIT);

	adc_bit_clock u_clk (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.run_in(run),
		.conv_clk_sel_in(conv_clk_sel_in),
		.rc_clk_in(rc_clk_in),
		.tick_out(tick)
	);

	adc_sar_core #(.W(W)) u_sar (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.start_in(sar_start),
		.step_in(tick && st_q == adc_seq_pkg::ST_CONVERT),
		.comp_above_in(cmp_s2_q),
		.trial_out(dac_trial_out),
		.value_out(sar_val)
	);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// One state walk for all phases. Go stays high through acquisition and
	// conversion so software cannot tell them apart.
	always_comb begin
		st_d = st_q;
		go_d = go_q;
		per_d = per_q;
		dly_d = dly_q;
		sar_start = 1'b0;
		done_evt = 1'b0;
		if (go_set_in || (trigger_in && conv_power_on_in)) begin
			go_d = 1'b1;
		end
		if (go_clr_in) begin
			go_d = 1'b0;
		end
		unique case (st_q)
			adc_seq_pkg::ST_IDLE: begin
				if (go_q && conv_power_on_in) begin
					per_d = 5'h00;
					dly_d = 8'h00;
					if (acq_periods != 5'h00) begin
						st_d = adc_seq_pkg::ST_ACQUIRE;
					end else if (conv_clk_sel_in[1:0] == 2'h3) begin
						st_d = adc_seq_pkg::ST_START_DELAY;
					end else begin
						st_d = adc_seq_pkg::ST_CONVERT;
						sar_start = 1'b1;
					end
				end
			end
			adc_seq_pkg::ST_START_DELAY: begin
				dly_d = dly_q + 8'h01;
				if (dly_q == adc_seq_pkg::INSTR_CYCLE_CLKS - 8'h01) begin
					st_d = adc_seq_pkg::ST_CONVERT;
					sar_start = 1'b1;
				end
			end
			adc_seq_pkg::ST_ACQUIRE: begin
				if (tick) begin
					per_d = per_q + 5'h01;
					if (per_q == acq_periods - 5'h01) begin
						per_d = 5'h00;
						st_d = adc_seq_pkg::ST_CONVERT;
						sar_start = 1'b1;
					end
				end
			end
			adc_seq_pkg::ST_CONVERT: begin
				if (tick) begin
					per_d = per_q + 5'h01;
					if (per_q == adc_seq_pkg::CONV_PERIODS - 5'h01) begin
						per_d = 5'h00;
						st_d = adc_seq_pkg::ST_POST_WAIT;
						done_evt = 1'b1;
						go_d = 1'b0;
					end
				end
			end
			adc_seq_pkg::ST_POST_WAIT: begin
				if (tick) begin
					per_d = per_q + 5'h01;
					if (per_q == adc_seq_pkg::POST_WAIT_PERIODS - 5'h01) begin
						st_d = adc_seq_pkg::ST_IDLE;
						per_d = 5'h00;
					end
				end
			end
		endcase
		// Abort by software clear or power off. A clear that lands on the last
		// tick comes too late: go_q is still high, so the completion writes the pair.
		if ((st_q == adc_seq_pkg::ST_ACQUIRE || st_q == adc_seq_pkg::ST_CONVERT
			|| st_q == adc_seq_pkg::ST_START_DELAY)
			&& (!go_q || !conv_power_on_in)) begin
			st_d = adc_seq_pkg::ST_POST_WAIT;
			per_d = 5'h00;
			done_evt = 1'b0;
		end
		if (!conv_power_on_in) begin
			go_d = 1'b0;
		end
	end

	// Done flag: a completion in the clear cycle still sets it.
	always_comb begin
		flag_d = flag_q;
		if (done_flag_clr_in) begin
			flag_d = 1'b0;
		end
		if (done_evt) begin
			flag_d = 1'b1;
		end
	end

	// Result pair only changes on completion or software write.
	always_comb begin
		rh_d = rh_q;
		rl_d = rl_q;
		if (result_wr_in) begin
			rh_d = result_high_byte_wr_in;
			rl_d = result_low_byte_wr_in;
		end
		if (done_evt) begin
			if (result_justify_sel_in) begin
				rh_d = {6'h00, sar_val[9:8]};
				rl_d = sar_val[7:0];
			end else begin
				rh_d = sar_val[9:2];
				rl_d = {sar_val[1:0], 6'h00};
			end
		end
	end

	// Reset clears go, the flag, the counters and the result pair, and returns the sequencer to idle.
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			st_q <= adc_seq_pkg::ST_IDLE;
			go_q <= 1'b0;
			flag_q <= 1'b0;
			per_q <= 5'h00;
			dly_q <= 8'h00;
			rh_q <= 8'h00;
			rl_q <= 8'h00;
		end else begin
			st_q <= st_d;
			go_q <= go_d;
			flag_q <= flag_d;
			per_q <= per_d;
			dly_q <= dly_d;
			rh_q <= rh_d;
			rl_q <= rl_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// The pin stays connected except during conversion, whatever its
	// direction or digital setting.
	assign sample_connect_out = (st_q != adc_seq_pkg::ST_CONVERT);
	assign go_out = go_q;
	assign conv_done_irq_flag_out = flag_q;
	assign result_high_byte_out = rh_q;
	assign result_low_byte_out = rl_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_finish;
		st_q == adc_seq_pkg::ST_CONVERT && tick && go_q && conv_power_on_in
			&& per_q == adc_seq_pkg::CONV_PERIODS - 5'h01;
	endsequence

	a_done_flag_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		s_finish |=> conv_done_irq_flag_out && !go_out)
		else $error("completion did not set flag and clear go");
	a_post_wait_go: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		s_finish |=> st_q == adc_seq_pkg::ST_POST_WAIT)
		else $error("no wait after completion");
	a_abort_keeps: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(st_q == adc_seq_pkg::ST_CONVERT && !go_q && !result_wr_in)
		|=> $stable(result_high_byte_out) && $stable(result_low_byte_out))
		else $error("abort changed result");
	a_manual_start: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(st_q == adc_seq_pkg::ST_IDLE && go_q && conv_power_on_in
		&& acq_time_sel_in == 3'h0 && conv_clk_sel_in[1:0] != 2'h3)
		|=> !sample_connect_out)
		else $error("manual start not immediate");
	a_auto_acquire: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(st_q == adc_seq_pkg::ST_IDLE && go_q && conv_power_on_in
		&& acq_time_sel_in != 3'h0 && !go_clr_in)
		|=> sample_connect_out && go_out)
		else $error("auto acquisition skipped");
	a_rc_delay: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(st_q == adc_seq_pkg::ST_IDLE && go_q && conv_power_on_in
		&& acq_time_sel_in == 3'h0 && conv_clk_sel_in[1:0] == 2'h3 && !go_clr_in)
		|=> sample_connect_out [*4])
		else $error("RC start not delayed");
	a_trigger_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(!go_q && trigger_in && !conv_power_on_in && !go_set_in) |=> !go_q)
		else $error("trigger set go while off");
	a_analog_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(pin_analog_in != '0) |-> ((port_read_out & pin_analog_in) == '0))
		else $error("analog pin read nonzero");

endmodule : adc_acquire_convert_sequencer

`default_nettype wire

/* File: dv/tb_adc_acquire_convert_sequencer.sv */
// Self-checking bench for the acquire and convert sequencer.
// Assumes the design's 25 MHz clock, synchronous active-low reset and the
// hand-over latencies; the bench plays software, comparator and RC source.
`timescale 1ns/1ns
`default_nettype none

module tb_adc_acquire_convert_sequencer;

	// ****************************************************************
	// Stimulus, design instance and model state
	// ****************************************************************
	localparam int NP = 13;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic conv_power_on_in = 1'b0, go_set_in = 1'b0, go_clr_in = 1'b0, trigger_in = 1'b0;
	logic [2:0] acq_time_sel_in = 3'h0, conv_clk_sel_in = 3'h0;
	logic result_justify_sel_in = 1'b0, result_wr_in = 1'b0, done_flag_clr_in = 1'b0;
	logic [7:0] result_high_byte_wr_in = 8'h00, result_low_byte_wr_in = 8'h00;
	logic rc_clk_in = 1'b0, comp_above_in = 1'b0;
	logic [NP-1:0] pin_level_in = '0, pin_analog_in = '0;
	logic go_out, conv_done_irq_flag_out, sample_connect_out;
	logic [adc_seq_pkg::RESULT_W-1:0] dac_trial_out;
	logic [7:0] result_high_byte_out, result_low_byte_out;
	logic [NP-1:0] port_read_out;
	int miscompares = 0, n_tests = 0, vin_m = 0, rc_n = 0;
	int res_q[$];
	logic [15:0] res_m = 16'h0000;

	adc_acquire_convert_sequencer #(.NPINS(NP)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.conv_power_on_in(conv_power_on_in), .go_set_in(go_set_in), .go_clr_in(go_clr_in),
		.trigger_in(trigger_in), .acq_time_sel_in(acq_time_sel_in),
		.conv_clk_sel_in(conv_clk_sel_in), .result_justify_sel_in(result_justify_sel_in),
		.result_wr_in(result_wr_in), .result_high_byte_wr_in(result_high_byte_wr_in),
		.result_low_byte_wr_in(result_low_byte_wr_in), .done_flag_clr_in(done_flag_clr_in),
		.rc_clk_in(rc_clk_in), .comp_above_in(comp_above_in), .pin_level_in(pin_level_in),
		.pin_analog_in(pin_analog_in), .go_out(go_out),
		.conv_done_irq_flag_out(conv_done_irq_flag_out),
		.sample_connect_out(sample_connect_out), .dac_trial_out(dac_trial_out),
		.result_high_byte_out(result_high_byte_out), .result_low_byte_out(result_low_byte_out),
		.port_read_out(port_read_out));

	// The clock, and an RC source of 18 clocks that runs free as a real oscillator does.
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		rc_n <= (rc_n == 8) ? 0 : rc_n + 1;
		if (rc_n == 8) rc_clk_in <= ~rc_clk_in;
	end

	// Comparator of an input half an LSB above vin_m, so the ideal result is vin_m exactly.
	always @(posedge clk_in) begin
		comp_above_in <= (vin_m >= int'(dac_trial_out));
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	// Bit period in clocks; both RC codes share the 18-clock source.
	function automatic int div_of(input int s);
		case (s)
			0: div_of = 2;
			4: div_of = 4;
			1: div_of = 8;
			5: div_of = 16;
			2: div_of = 32;
			6: div_of = 64;
			default: div_of = 18;
		endcase
	endfunction : div_of

	function automatic logic [15:0] pack(input int r, input logic j);
		logic [9:0] v;
		v = r[9:0];
		pack = j ? {6'h00, v} : {v, 6'h00};
	endfunction : pack

	// One-hot strobe masks: go set, go clear, trigger, flag clear, result write.
	localparam logic [4:0] P_GO = 5'h10;
	localparam logic [4:0] P_CLR = 5'h08;
	localparam logic [4:0] P_TRIG = 5'h04;
	localparam logic [4:0] P_DCLR = 5'h02;
	localparam logic [4:0] P_WR = 5'h01;

	// A mask keeps all strobes in one driver, so no signal is passed by reference.
	task automatic pulse(input logic [4:0] m);
		@(posedge clk_in);
		{go_set_in, go_clr_in, trigger_in, done_flag_clr_in, result_wr_in} <= m;
		@(posedge clk_in);
		{go_set_in, go_clr_in, trigger_in, done_flag_clr_in, result_wr_in} <= 5'h00;
	endtask : pulse

	// One go request; timing measured in clocks from go to completion or abort.
	task automatic convert(input int acq, input int cs, input logic j, input int vin,
			input int extra, input bit abort);
		int acq_tbl[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
		int div, exp_t, t, low_n;
		bit ok;
		div = div_of(cs);
		acq_time_sel_in <= acq[2:0];
		conv_clk_sel_in <= cs[2:0];
		result_justify_sel_in <= j;
		vin_m = vin;
		pulse(P_GO);
		t = 0;
		low_n = 0;
		@(negedge clk_in);
		while (go_out === 1'b1 && t < 4000) begin
			t++;
			if (sample_connect_out === 1'b0) begin
				low_n++;
				if (low_n == 1) check(16'(dac_trial_out), 16'h0200);
			end
			if (abort && low_n == 3 * div) pulse(P_CLR);
			@(negedge clk_in);
		end
		check(go_out, 1'b0);
		if (abort) begin
			check(conv_done_irq_flag_out, 1'b0);
			check({result_high_byte_out, result_low_byte_out}, res_m);
			return;
		end
		exp_t = (acq_tbl[acq] + 11 + extra) * div + ((acq == 0 && div == 18) ? 4 : 0);
		// The free RC source may tick up to one period early after the start.
		ok = (t >= exp_t - ((div == 18) ? div : 0) - 6) && (t <= exp_t + div + 6);
		check({15'h0, ok}, 16'h0001);
		ok = (low_n >= 10 * div) && (low_n <= 11 * div + 2);
		check({15'h0, ok}, 16'h0001);
		check(conv_done_irq_flag_out, 1'b1);
		check(sample_connect_out, 1'b1);
		res_q.push_back(pack(vin, j));
		res_m = res_q.pop_front();
		if (div >= 8) check({result_high_byte_out, result_low_byte_out}, res_m);
		repeat (3) @(negedge clk_in);
		check(conv_done_irq_flag_out, 1'b1);
		pulse(P_DCLR);
		@(negedge clk_in);
		check(conv_done_irq_flag_out, 1'b0);
	endtask : convert

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(59));
		repeat (5) @(posedge clk_in);
		rst_b_in <= 1'b1;
		@(negedge clk_in);
		check({go_out, conv_done_irq_flag_out, sample_connect_out}, 16'h0001);
		// A go request or trigger with power off is dropped.
		pulse(P_GO);
		pulse(P_TRIG);
		repeat (2) @(negedge clk_in);
		check(go_out, 1'b0);
		@(posedge clk_in) conv_power_on_in <= 1'b1;
		// Every clock code and every acquisition code once, both justifications.
		for (int i = 0; i < 8; i++) begin
			convert(i, i, i[0], $urandom_range(1023), 0, 0);
			repeat (200) @(posedge clk_in);
		end
		convert(0, 3, 1'b0, $urandom_range(1023), 0, 0);
		repeat (60) @(posedge clk_in);
		// Back to back: the second request waits out the two-period gap.
		convert(2, 1, 1'b1, 10'h3ff, 0, 0);
		convert(2, 1, 1'b0, 10'h001, 2, 0);
		repeat (40) @(posedge clk_in);
		// Trigger with power on starts a conversion.
		vin_m = 555;
		pulse(P_TRIG);
		repeat (2) @(negedge clk_in);
		check(go_out, 1'b1);
		while (go_out === 1'b1) @(negedge clk_in);
		pulse(P_DCLR);
		res_q.push_back(pack(555, 1'b0));
		res_m = res_q.pop_front();
		check({result_high_byte_out, result_low_byte_out}, res_m);
		// A software write, then an abort that must not disturb it.
		result_high_byte_wr_in <= 8'($urandom);
		result_low_byte_wr_in <= 8'($urandom);
		pulse(P_WR);
		@(negedge clk_in);
		res_m = {result_high_byte_wr_in, result_low_byte_wr_in};
		check({result_high_byte_out, result_low_byte_out}, res_m);
		convert(0, 1, 1'b1, 700, 0, 1);
		repeat (30) @(posedge clk_in);
		// Digital reads of analog pins give zero.
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_in);
			pin_level_in <= NP'($urandom);
			pin_analog_in <= NP'($urandom);
			repeat (4) @(negedge clk_in);
			check(16'(port_read_out), 16'(pin_level_in & ~pin_analog_in));
		end
		// Reset in mid conversion clears everything and aborts.
		acq_time_sel_in <= 3'h0;
		conv_clk_sel_in <= 3'h6;
		pulse(P_GO);
		repeat (100) @(posedge clk_in);
		rst_b_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		rst_b_in <= 1'b1;
		@(negedge clk_in);
		check({go_out, conv_done_irq_flag_out, sample_connect_out}, 16'h0001);
		check({result_high_byte_out, result_low_byte_out}, 16'h0000);
		wrap_up();
	end

	// Watchdog well beyond the longest path of the sequence above.
	initial begin
		#(40 * 80000);
		miscompares++;
		wrap_up();
	end

endmodule : tb_adc_acquire_convert_sequencer

`default_nettype wire
